// *** hdl/scfd_params.svh ***
/*
  Constants of the speech codec fixed-point datapath: saturation limits,
  rounding and scaling figures, frame geometry and valid-bit masks.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef SCFD_PARAMS_SVH
`define SCFD_PARAMS_SVH

// Saturation limits
`define SCFD_MAX16      16'h7FFF
`define SCFD_MIN16      16'h8000
`define SCFD_MAX32      32'h7FFFFFFF
`define SCFD_MIN32      32'h80000000
// Rounding constant of the rounding multiplier, already 32 bits wide
`define SCFD_ROUND      32'h00004000
// De-emphasis coefficient, 28180 in Q15
`define SCFD_BETA       16'h6E14
// Frame geometry
`define SCFD_FRAME_LAST 8'h9F
`define SCFD_SUB_LAST   6'h27
`define SCFD_PULSE_LAST 4'hC
`define SCFD_PHASE_LAST 2'h2
`define SCFD_DIV_STEPS  4'hF
// Valid-bit masks for received samples and coded parameters
`define SCFD_SMP_MASK   16'hFFF8
`define SCFD_LAG_MASK   16'h007F
`define SCFD_GAIN_MASK  16'h0003
`define SCFD_GRID_MASK  16'h0003
`define SCFD_XMAX_MASK  16'h003F
`define SCFD_PULSE_MASK 16'h0007
`define SCFD_LAR_MASK   {16'h0007, 16'h0007, 16'h000F, 16'h000F, \
                         16'h001F, 16'h001F, 16'h003F, 16'h003F}

`endif

// *** hdl/scfd_pkg.sv ***
/*
  Types and saturating arithmetic helpers of the speech codec datapath.
  Assumes the constants header is on the include path.
*/
`include "scfd_params.svh"

package scfd_pkg;

  // Only two data widths are carried
  typedef logic signed [15:0] scfd_word_t;
  typedef logic signed [31:0] scfd_long_t;

  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_MULT, OP_MULT_R, OP_ABS, OP_DIV, OP_L_MULT, OP_L_ADD,
    OP_L_SUB, OP_NORM, OP_SHL, OP_SHR, OP_L_SHL, OP_L_SHR, OP_DEPOSIT, OP_EXTRACT
  } scfd_op_e;

  typedef struct packed {
    scfd_op_e   op;
    scfd_long_t a;
    scfd_long_t b;
  } scfd_op_req_s;

  typedef struct packed {
    logic       valid;
    scfd_long_t result;
  } scfd_op_rsp_s;

  typedef struct packed {
    logic [1:0]        grid;
    scfd_word_t [12:0] pulses;
  } scfd_rpe_s;

  typedef struct packed {
    scfd_word_t [7:0] coded_area_ratios;
  } scfd_frame_par_s;

  typedef struct packed {
    scfd_word_t        lag;
    scfd_word_t        coded_predictor_gain;
    scfd_word_t        grid_selection;
    scfd_word_t        block_max;
    scfd_word_t [12:0] coded_pulse_values;
  } scfd_sub_par_s;

  // Reflection coefficient i sits at index i-1
  typedef scfd_word_t [7:0] scfd_coef_t;

  function automatic scfd_long_t sext16(input scfd_word_t w);
    return {{16{w[15]}}, w};
  endfunction : sext16

  // Clamp a long value into the word range
  function automatic scfd_word_t sat16(input scfd_long_t v);
    if (v[31:15] != {17{v[31]}})
      return v[31] ? `SCFD_MIN16 : `SCFD_MAX16;
    return v[15:0];
  endfunction : sat16

  function automatic scfd_word_t add16(input scfd_word_t a, input scfd_word_t b);
    return sat16(sext16(a) + sext16(b));
  endfunction : add16

  function automatic scfd_word_t sub16(input scfd_word_t a, input scfd_word_t b);
    return sat16(sext16(a) - sext16(b));
  endfunction : sub16

  function automatic scfd_word_t mult16(input scfd_word_t a, input scfd_word_t b,
                                        input logic rnd);
    scfd_long_t p;
    p = sext16(a) * sext16(b);
    if (rnd)
      p = p + `SCFD_ROUND;
    if (a == `SCFD_MIN16 && b == `SCFD_MIN16)
      return `SCFD_MAX16;
    return p[30:15];
  endfunction : mult16

  function automatic scfd_long_t l_addsub(input scfd_long_t a, input scfd_long_t b,
                                          input logic sub);
    logic signed [32:0] s;
    s = sub ? ({a[31], a} - {b[31], b}) : ({a[31], a} + {b[31], b});
    if (s[32] != s[31])
      return s[32] ? `SCFD_MIN32 : `SCFD_MAX32;
    return s[31:0];
  endfunction : l_addsub

  // Left shifts fill with zeros, right shifts copy the sign
  function automatic scfd_long_t shift32(input scfd_long_t v, input scfd_word_t n,
                                         input logic left);
    logic       go_left;
    logic [15:0] mag;
    go_left = left ^ n[15];
    mag     = n[15] ? 16'(-n) : 16'(n);
    if (mag > 16'h001F)
      return go_left ? '0 : {32{v[31]}};
    return go_left ? (v << mag[4:0]) : (v >>> mag[4:0]);
  endfunction : shift32

endpackage : scfd_pkg

// *** hdl/scfd_divider.sv ***
/*
  Fractional divider: restoring division of a numerator by a denominator
  that is not smaller, giving a positive Q15 quotient in one cycle.
  Assumes the caller presents 0 < numerator <= denominator.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scfd_params.svh"

module scfd_divider
  import scfd_pkg::*;
(
  // Operands
  input  wire scfd_word_t num_in,
  input  wire scfd_word_t den_in,
  // Quotient
  output scfd_word_t      quo_out
);

  // Fifteen restoring steps, one quotient bit each
  always_comb
  begin
    scfd_long_t rem;
    scfd_word_t q;
    rem = sext16(num_in);
    q   = '0;
    for (int k = 0; k < 15; k++)
    begin
      q   = q << 1;
      rem = rem << 1;
      if (rem >= sext16(den_in))
      begin
        rem = rem - sext16(den_in);
        q   = q + 16'h0001;
      end
    end
    // Equal operands land on the largest positive word
    if (num_in == den_in)
      q = `SCFD_MAX16;
    quo_out = q;
  end

endmodule : scfd_divider

`default_nettype wire

// *** hdl/scfd_synth.sv ***
/*
  Short-term synthesis lattice with de-emphasis: one sample in, one
  sample out a cycle later. Assumes coefficients are steady while used.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scfd_params.svh"

module scfd_synth
  import scfd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  // Residual sample and coefficients
  input  wire logic       res_valid_in,
  input  wire scfd_word_t res_in,
  input  wire scfd_coef_t coef_in,
  // Output speech
  output logic            spc_valid_out,
  output scfd_word_t      spc_out
);

  typedef struct packed {
    logic       valid;
    scfd_word_t deemph;
    scfd_word_t [7:0] v;
  } scfd_syn_state_s;

  scfd_syn_state_s syn_ff;
  scfd_syn_state_s nxt_syn;

  // Lattice runs stages 1..8 with coefficients taken in reverse order
  always_comb
  begin
    scfd_word_t sri;
    sri     = res_in;
    nxt_syn = syn_ff;
    nxt_syn.valid = res_valid_in;
    if (res_valid_in)
    begin
      for (int i = 1; i <= 8; i++)
      begin
        sri = sub16(sri, mult16(coef_in[8-i], syn_ff.v[8-i], 1'b1));
        if (i > 1)
          nxt_syn.v[9-i] = add16(syn_ff.v[8-i], mult16(coef_in[8-i], sri, 1'b1));
      end
      nxt_syn.v[0] = sri;
      // Feedback of the previous output by beta
      nxt_syn.deemph = add16(sri, mult16(syn_ff.deemph, `SCFD_BETA, 1'b1));
    end
  end

  // State survives frames; only reset clears it
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      syn_ff <= '0;
    else if (ce_in)
      syn_ff <= nxt_syn;
  end

  assign spc_valid_out = syn_ff.valid;
  assign spc_out       = syn_ff.deemph;

endmodule : scfd_synth

`default_nettype wire

// *** hdl/scfd_top.sv ***
/*
  Speech codec fixed-point datapath top: the arithmetic primitives behind
  a strobed request port, received-sample masking and frame timing,
  coded parameter delivery, RPE grid up-sampling and the synthesis tail.
  Assumes the codec sequencing logic on the same clock drives all inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scfd_params.svh"

module scfd_top
  import scfd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic            ce_in,
  // Arithmetic request and answer
  input  wire logic            op_valid_in,
  input  wire scfd_op_req_s    op_req_in,
  output scfd_op_rsp_s         op_rsp_out,
  // Received samples and frame timing
  input  wire logic            smp_valid_in,
  input  wire scfd_word_t      smp_in,
  output logic                 smp_valid_out,
  output scfd_word_t           smp_out,
  output logic [7:0]           smp_index_out,
  output logic [1:0]           sub_index_out,
  output logic                 frame_start_out,
  // Coded parameters
  input  wire logic            frame_par_valid_in,
  input  wire scfd_frame_par_s frame_par_in,
  input  wire logic            sub_par_valid_in,
  input  wire scfd_sub_par_s   sub_par_in,
  output logic                 frame_par_valid_out,
  output scfd_frame_par_s      frame_par_out,
  output logic                 sub_par_valid_out,
  output scfd_sub_par_s        sub_par_out,
  // RPE grid positioning
  input  wire logic            rpe_valid_in,
  input  wire scfd_rpe_s       rpe_in,
  output logic                 rpe_ready_out,
  output logic                 exc_valid_out,
  output scfd_word_t           exc_out,
  // Synthesis tail
  input  wire logic            res_valid_in,
  input  wire scfd_word_t      res_in,
  input  wire scfd_coef_t      coef_in,
  output logic                 spc_valid_out,
  output scfd_word_t           spc_out
);

  typedef struct packed {
    // Arithmetic answer
    scfd_op_rsp_s      alu;
    // Sample path and frame timing
    logic              smp_valid;
    scfd_word_t        smp;
    logic [7:0]        smp_idx;
    logic [5:0]        sub_pos;
    logic [1:0]        sub_idx;
    logic              frame_start;
    // Parameter path
    scfd_frame_par_s   frame_par;
    scfd_sub_par_s     sub_par;
    logic              frame_pend;
    logic              sub_pend;
    logic              frame_par_valid;
    logic              sub_par_valid;
    // Up-sampler
    logic              rpe_busy;
    logic              rpe_ready;
    logic [5:0]        rpe_k;
    logic [1:0]        rpe_wait;
    logic [1:0]        rpe_phase;
    logic [3:0]        rpe_idx;
    scfd_word_t [12:0] rpe_pulses;
    logic              exc_valid;
    scfd_word_t        exc;
  } scfd_top_state_s;

  scfd_top_state_s st_ff;
  scfd_top_state_s nxt_st;
  scfd_word_t      div_q;
  localparam logic [7:0][15:0] lar_mask = `SCFD_LAR_MASK;

  // Divider sits outside the request decode so its loop stays in one place
  scfd_divider u_div (
    .num_in  (op_req_in.a[15:0]),
    .den_in  (op_req_in.b[15:0]),
    .quo_out (div_q)
  );

  // Synthesis lattice and de-emphasis keep their own state
  scfd_synth u_syn (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .ce_in         (ce_in),
    .res_valid_in  (res_valid_in),
    .res_in        (res_in),
    .coef_in       (coef_in),
    .spc_valid_out (spc_valid_out),
    .spc_out       (spc_out)
  );

  // Word results travel sign-extended in the long result field
  function automatic scfd_long_t alu_eval(input scfd_op_req_s r, input scfd_word_t q);
    scfd_word_t a16;
    scfd_word_t b16;
    scfd_long_t t;
    a16 = r.a[15:0];
    b16 = r.b[15:0];
    t   = '0;
    unique case (r.op)
      OP_ADD:     t = sext16(add16(a16, b16));
      OP_SUB:     t = sext16(sub16(a16, b16));
      OP_MULT:    t = sext16(mult16(a16, b16, 1'b0));
      OP_MULT_R:  t = sext16(mult16(a16, b16, 1'b1));
      OP_ABS:
      begin
        if (a16 == `SCFD_MIN16)
          t = sext16(`SCFD_MAX16);
        else
          t = a16[15] ? -sext16(a16) : sext16(a16);
      end
      OP_DIV:     t = sext16(q);
      // The doubled product of the one excluded corner is not guarded
      OP_L_MULT:  t = (sext16(a16) * sext16(b16)) <<< 1;
      OP_L_ADD:   t = l_addsub(r.a, r.b, 1'b0);
      OP_L_SUB:   t = l_addsub(r.a, r.b, 1'b1);
      OP_NORM:    t = sext16(norm_count(r.a));
      OP_SHL:     t = sext16(16'(shift32(sext16(a16), b16, 1'b1)));
      OP_SHR:     t = sext16(16'(shift32(sext16(a16), b16, 1'b0)));
      OP_L_SHL:   t = shift32(r.a, b16, 1'b1);
      OP_L_SHR:   t = shift32(r.a, b16, 1'b0);
      // Short constants reach long operations through this same widening
      OP_DEPOSIT: t = sext16(a16);
      OP_EXTRACT: t = sext16(r.a[15:0]);
    endcase
    return t;
  endfunction : alu_eval

  // Leading sign bits minus one; zero stays zero
  function automatic scfd_word_t norm_count(input scfd_long_t v);
    scfd_long_t y;
    logic       done;
    scfd_word_t cnt;
    y    = v[31] ? ~v : v;
    done = 1'b0;
    cnt  = '0;
    for (int i = 30; i >= 0; i--)
    begin
      if (!done)
      begin
        if (y[i])
          done = 1'b1;
        else
          cnt = cnt + 16'h0001;
      end
    end
    if (v == '0)
      cnt = '0;
    return cnt;
  endfunction : norm_count

  // Keep only the valid low bits of a coded parameter
  function automatic scfd_word_t par_mask(input scfd_word_t w, input logic [15:0] m);
    return w & m;
  endfunction : par_mask

  // Next-state logic for every path of the top except the synthesis tail, which u_syn keeps
  always_comb
  begin
    nxt_st = st_ff;

    // Arithmetic answer, one cycle after the request strobe
    nxt_st.alu.valid = op_valid_in;
    if (op_valid_in)
      nxt_st.alu.result = alu_eval(op_req_in, div_q);

    // Sample path: low three bits are noise on reception
    nxt_st.smp_valid   = smp_valid_in;
    nxt_st.frame_start = 1'b0;
    nxt_st.frame_par_valid = 1'b0;
    nxt_st.sub_par_valid   = 1'b0;
    if (smp_valid_in)
    begin
      nxt_st.smp         = smp_in & `SCFD_SMP_MASK;
      nxt_st.frame_start = (st_ff.smp_idx == 8'h00);
      if (st_ff.smp_idx == `SCFD_FRAME_LAST)
        nxt_st.smp_idx = 8'h00;
      else
        nxt_st.smp_idx = st_ff.smp_idx + 8'h01;
      if (st_ff.sub_pos == `SCFD_SUB_LAST)
      begin
        nxt_st.sub_pos = 6'h00;
        nxt_st.sub_idx = st_ff.sub_idx + 2'h1;
        // Subsegment codes leave as their 40 samples are done
        if (st_ff.sub_pend)
        begin
          nxt_st.sub_par_valid = 1'b1;
          nxt_st.sub_pend      = 1'b0;
        end
        // Area ratio codes leave once the whole frame is through
        if (st_ff.smp_idx == `SCFD_FRAME_LAST && st_ff.frame_pend)
        begin
          nxt_st.frame_par_valid = 1'b1;
          nxt_st.frame_pend      = 1'b0;
        end
      end
      else
        nxt_st.sub_pos = st_ff.sub_pos + 6'h01;
    end

    // Capture coded parameters, stripping the invalid high bits
    if (frame_par_valid_in)
    begin
      for (int i = 0; i < 8; i++)
        nxt_st.frame_par.coded_area_ratios[i] =
          par_mask(frame_par_in.coded_area_ratios[i], lar_mask[i]);
      nxt_st.frame_pend = 1'b1;
    end
    if (sub_par_valid_in)
    begin
      nxt_st.sub_par.lag = par_mask(sub_par_in.lag, `SCFD_LAG_MASK);
      nxt_st.sub_par.coded_predictor_gain =
        par_mask(sub_par_in.coded_predictor_gain, `SCFD_GAIN_MASK);
      nxt_st.sub_par.grid_selection =
        par_mask(sub_par_in.grid_selection, `SCFD_GRID_MASK);
      nxt_st.sub_par.block_max = par_mask(sub_par_in.block_max, `SCFD_XMAX_MASK);
      for (int i = 0; i < 13; i++)
        nxt_st.sub_par.coded_pulse_values[i] =
          par_mask(sub_par_in.coded_pulse_values[i], `SCFD_PULSE_MASK);
      nxt_st.sub_pend = 1'b1;
    end

    // Up-sampler: zeros before the grid offset, then one pulse in three
    nxt_st.exc_valid = 1'b0;
    if (!st_ff.rpe_busy && rpe_valid_in)
    begin
      nxt_st.rpe_busy   = 1'b1;
      nxt_st.rpe_pulses = rpe_in.pulses;
      nxt_st.rpe_wait   = rpe_in.grid;
      nxt_st.rpe_phase  = 2'h0;
      nxt_st.rpe_idx    = 4'h0;
      nxt_st.rpe_k      = 6'h00;
    end
    else if (st_ff.rpe_busy)
    begin
      nxt_st.exc_valid = 1'b1;
      nxt_st.exc       = '0;
      if (st_ff.rpe_wait != 2'h0)
        nxt_st.rpe_wait = st_ff.rpe_wait - 2'h1;
      else
      begin
        if (st_ff.rpe_phase == 2'h0 && st_ff.rpe_idx <= `SCFD_PULSE_LAST)
        begin
          nxt_st.exc     = st_ff.rpe_pulses[st_ff.rpe_idx];
          nxt_st.rpe_idx = st_ff.rpe_idx + 4'h1;
        end
        nxt_st.rpe_phase = (st_ff.rpe_phase == `SCFD_PHASE_LAST) ? 2'h0
                                                                 : st_ff.rpe_phase + 2'h1;
      end
      if (st_ff.rpe_k == `SCFD_SUB_LAST)
        nxt_st.rpe_busy = 1'b0;
      else
        nxt_st.rpe_k = st_ff.rpe_k + 6'h01;
    end
    // Ready is registered so the port comes straight from a flip-flop
    nxt_st.rpe_ready = !nxt_st.rpe_busy;
  end

  // Single register stage for all top state; enable low freezes it
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      st_ff <= '{rpe_ready: 1'b1, default: '0};
    else if (ce_in)
      st_ff <= nxt_st;
  end

  // Outputs straight from the state register
  assign op_rsp_out          = st_ff.alu;
  assign smp_valid_out       = st_ff.smp_valid;
  assign smp_out             = st_ff.smp;
  assign smp_index_out       = st_ff.smp_idx;
  assign sub_index_out       = st_ff.sub_idx;
  assign frame_start_out     = st_ff.frame_start;
  assign frame_par_valid_out = st_ff.frame_par_valid;
  assign frame_par_out       = st_ff.frame_par;
  assign sub_par_valid_out   = st_ff.sub_par_valid;
  assign sub_par_out         = st_ff.sub_par;
  assign rpe_ready_out       = st_ff.rpe_ready;
  assign exc_valid_out       = st_ff.exc_valid;
  assign exc_out             = st_ff.exc;

endmodule : scfd_top

`default_nettype wire

// *** test/scfd_top_asserts.sv ***
/*
  Checker of the datapath top: answer timing, corner results, sample
  masking, frame counting and the up-sampler burst.
  Assumes it is bound to scfd_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module scfd_top_chk
  import scfd_pkg::*;
(
  // Clock and reset
  input wire logic         clk_in,
  input wire logic         rst_n_in,
  // Watched ports
  input wire logic         ce_in,
  input wire logic         op_valid_in,
  input wire scfd_op_req_s op_req_in,
  input wire scfd_op_rsp_s op_rsp_out,
  input wire logic         smp_valid_in,
  input wire scfd_word_t   smp_in,
  input wire logic         smp_valid_out,
  input wire scfd_word_t   smp_out,
  input wire logic [7:0]   smp_index_out,
  input wire logic         frame_start_out,
  input wire logic         sub_par_valid_out,
  input wire logic         rpe_valid_in,
  input wire logic         rpe_ready_out,
  input wire logic         exc_valid_out,
  input wire logic         res_valid_in,
  input wire logic         spc_valid_out
);
  // One clock domain; reset silences every check
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Up-sampler steps: taken, busy, then a run of samples
  sequence rpe_take_s;
    ce_in && rpe_valid_in && rpe_ready_out;
  endsequence
  sequence rpe_burst_s;
    !rpe_ready_out ##1 exc_valid_out [*8];
  endsequence

  // Both word operands at the most negative value
  logic both_min;
  assign both_min = op_req_in.a[15:0] == 16'h8000 && op_req_in.b[15:0] == 16'h8000;

  alu_answer_a: assert property (ce_in && op_valid_in |=> op_rsp_out.valid)
    else $error("ALU answer missing");
  alu_quiet_a: assert property (ce_in && !op_valid_in |=> !op_rsp_out.valid)
    else $error("ALU answer without request");
  mult_corner_a: assert property (ce_in && op_valid_in && both_min &&
    (op_req_in.op == OP_MULT || op_req_in.op == OP_MULT_R) |=> op_rsp_out.result == 32'h7FFF)
    else $error("Multiply corner not saturated");
  abs_corner_a: assert property (ce_in && op_valid_in && op_req_in.op == OP_ABS &&
    op_req_in.a[15:0] == 16'h8000 |=> op_rsp_out.result == 32'h7FFF)
    else $error("Magnitude corner wrong");
  smp_mask_a: assert property (ce_in && smp_valid_in |=>
    smp_valid_out && smp_out == ($past(smp_in) & 16'hFFF8))
    else $error("Sample not masked");
  frame_wrap_a: assert property (ce_in && smp_valid_in && smp_index_out == 8'h9F
    |=> smp_index_out == 8'h00)
    else $error("Frame index did not wrap");
  frame_mark_a: assert property (ce_in && smp_valid_in && smp_index_out == 8'h00
    |=> frame_start_out)
    else $error("Frame start missing");
  sub_emit_a: assert property (sub_par_valid_out |-> $past(smp_valid_in) &&
    $past(smp_index_out) inside {8'h27, 8'h4F, 8'h77, 8'h9F})
    else $error("Subsegment codes at wrong time");
  rpe_burst_a: assert property (rpe_take_s |=> rpe_burst_s)
    else $error("Up-sampler burst wrong");
  spc_answer_a: assert property (ce_in && res_valid_in |=> spc_valid_out)
    else $error("Speech sample missing");
endmodule : scfd_top_chk

bind scfd_top scfd_top_chk u_chk (.clk_in, .rst_n_in, .ce_in, .op_valid_in, .op_req_in,
  .op_rsp_out, .smp_valid_in, .smp_in, .smp_valid_out, .smp_out, .smp_index_out,
  .frame_start_out, .sub_par_valid_out, .rpe_valid_in, .rpe_ready_out, .exc_valid_out,
  .res_valid_in, .spc_valid_out);

`default_nettype wire

// *** test/scfd_seq_model.sv ***
/*
  Stand-in for the codec sequencer: sends one frame of received samples
  with junk in the invalid low bits.
  Assumes the datapath takes one sample per clock on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module scfd_seq_model
  import scfd_pkg::*;
(
  // Clock and start request
  input wire logic       clk_in,
  input wire logic       start_in,
  // Sample stream
  output var logic       smp_valid_out,
  output var scfd_word_t smp_out
);
  logic [7:0]  left = 8'h00;
  logic [12:0] k    = 13'h0000;

  initial
  begin
    smp_valid_out = 1'b0;
    smp_out = 16'h0000;
  end

  // Exactly one frame per start; idle data is inverted so it never looks held
  always @(posedge clk_in)
  begin
    if (start_in)
      left = 8'hA0;
    #1;
    if (left != 8'h00)
    begin
      smp_valid_out = 1'b1;
      smp_out = {k, 3'h5};
      k = k + 13'h0001;
      left = left - 8'h01;
    end
    else
    begin
      smp_valid_out = 1'b0;
      smp_out = ~smp_out;
    end
  end
endmodule : scfd_seq_model

`default_nettype wire

// *** test/speech_codec_fixed_point_datapath_test.sv ***
/*
  Self-checking bench of the datapath top: arithmetic table, synthesis
  tail, one frame of samples with parameters, and every up-sampler grid.
  Assumes the checker is bound in and the sequencer model sends samples.
*/
`timescale 1ns/1ps
`default_nettype none

module speech_codec_fixed_point_datapath_test
  import scfd_pkg::*;
;
  // Design ports and bench state
  logic            clk_in, rst_n_in, ce_in, op_valid_in, smp_valid_in, seq_start;
  logic            frame_par_valid_in, sub_par_valid_in, rpe_valid_in, res_valid_in;
  logic            smp_valid_out, frame_start_out, frame_par_valid_out, sub_par_valid_out;
  logic            rpe_ready_out, exc_valid_out, spc_valid_out;
  logic [7:0]      smp_index_out;
  logic [1:0]      sub_index_out;
  scfd_op_req_s    op_req_in;
  scfd_op_rsp_s    op_rsp_out;
  scfd_word_t      smp_in, smp_out, exc_out, res_in, spc_out;
  scfd_frame_par_s frame_par_in, frame_par_out;
  scfd_sub_par_s   sub_par_in, sub_par_out;
  scfd_rpe_s       rpe_in;
  scfd_coef_t      coef_in;
  int              checked = 0;
  int              mismatches = 0;

  scfd_top uut (.clk_in, .rst_n_in, .ce_in, .op_valid_in, .op_req_in, .op_rsp_out,
    .smp_valid_in, .smp_in, .smp_valid_out, .smp_out, .smp_index_out, .sub_index_out,
    .frame_start_out, .frame_par_valid_in, .frame_par_in, .sub_par_valid_in, .sub_par_in,
    .frame_par_valid_out, .frame_par_out, .sub_par_valid_out, .sub_par_out, .rpe_valid_in,
    .rpe_in, .rpe_ready_out, .exc_valid_out, .exc_out, .res_valid_in, .res_in, .coef_in,
    .spc_valid_out, .spc_out);

  scfd_seq_model u_seq (.clk_in, .start_in(seq_start), .smp_valid_out(smp_valid_in),
    .smp_out(smp_in));

  task automatic check(input string what, input logic [271:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // One request per cycle; the strobe stays up between calls
  task automatic alu(input scfd_op_e op, input scfd_long_t a, b, want);
    op_valid_in = 1'b1;
    op_req_in = {op, a, b};
    @(posedge clk_in) #1;
    check(op.name(), {op_rsp_out.valid, op_rsp_out.result}, {1'b1, want});
  endtask : alu

  task automatic t_alu;
    alu(OP_ADD, 32'h7FFF, 32'h1, 32'h7FFF);
    alu(OP_SUB, 32'h8000, 32'h1, 32'hFFFF8000);
    alu(OP_MULT, 32'h8000, 32'h8000, 32'h7FFF);
    alu(OP_MULT, 32'h4000, 32'hC000, 32'hFFFFE000);
    alu(OP_MULT_R, 32'h1, 32'h4000, 32'h1);
    alu(OP_ABS, 32'h8000, 32'h0, 32'h7FFF);
    alu(OP_DIV, 32'h1, 32'h3, 32'h2AAA);
    alu(OP_DIV, 32'h3, 32'h3, 32'h7FFF);
    alu(OP_L_MULT, 32'h4000, 32'hC000, 32'hE0000000);
    alu(OP_L_ADD, 32'h7FFFFFFF, 32'h1, 32'h7FFFFFFF);
    alu(OP_L_ADD, 32'h10, 32'hFFFFFFFF, 32'hF);
    alu(OP_L_SUB, 32'h80000000, 32'h1, 32'h80000000);
    alu(OP_NORM, 32'h1, 32'h0, 32'h1E);
    alu(OP_NORM, 32'hE0000000, 32'h0, 32'h2);
    alu(OP_SHL, 32'hFFF0, 32'hFFFE, 32'hFFFFFFFC);
    alu(OP_SHR, 32'h3, 32'hFFFC, 32'h30);
    alu(OP_L_SHL, 32'h1, 32'h1F, 32'h80000000);
    alu(OP_L_SHR, 32'h80000000, 32'h4, 32'hF8000000);
    alu(OP_DEPOSIT, 32'h8000, 32'h0, 32'hFFFF8000);
    alu(OP_EXTRACT, 32'h12349ABC, 32'h0, 32'hFFFF9ABC);
    op_valid_in = 1'b0;
  endtask : t_alu

  // Only the first coefficient set: a stage order slip changes the output
  task automatic t_synth;
    scfd_word_t want [3] = '{16'h1000, 16'h05C3, 16'h08F4};
    coef_in = '0;
    coef_in[0] = 16'h4000;
    res_valid_in = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      res_in = (i == 0) ? 16'h1000 : 16'h0000;
      @(posedge clk_in) #1;
      check("spc", {spc_valid_out, spc_out}, {1'b1, want[i]});
    end
    ce_in = 1'b0;
    @(posedge clk_in) #1;
    check("hold", {spc_valid_out, spc_out}, {1'b1, want[2]});
    {res_valid_in, ce_in} = 2'h1;
  endtask : t_synth

  // Parameters loaded once, so only one subsegment emit may follow
  task automatic t_frame;
    logic [7:0] nsub = 8'h00;
    logic [7:0] nfrm = 8'h00;
    {sub_par_in, frame_par_in} = '1;
    {sub_par_valid_in, frame_par_valid_in, seq_start} = 3'h7;
    @(posedge clk_in) #1;
    {sub_par_valid_in, frame_par_valid_in, seq_start} = 3'h0;
    for (int k = 0; k < 8 && smp_valid_out !== 1'b1; k++)
      @(posedge clk_in) #1;
    for (int k = 0; k < 160; k++)
    begin
      check("smp", {smp_valid_out, frame_start_out, smp_out},
        {1'b1, 1'(k == 0), 13'(k), 3'h0});
      nsub += {7'h00, sub_par_valid_out};
      nfrm += {7'h00, frame_par_valid_out};
      @(posedge clk_in) #1;
    end
    check("sub_n", nsub, 1);
    check("frm_n", nfrm, 1);
    check("idx", {sub_index_out, smp_index_out}, 10'h000);
    check("sub", sub_par_out, {16'h7F, 16'h3, 16'h3, 16'h3F, {13{16'h7}}});
    check("frm", frame_par_out, {{2{16'h7}}, {2{16'hF}}, {2{16'h1F}}, {2{16'h3F}}});
  endtask : t_frame

  // Every grid; the strobe is held one cycle too long and must be refused
  task automatic t_rpe;
    int v;
    for (int k = 0; k < 13; k++)
      rpe_in.pulses[k] = 16'(k + 1);
    for (int g = 0; g < 4; g++)
    begin
      check("ready", rpe_ready_out, 1'b1);
      rpe_in.grid = 2'(g);
      rpe_valid_in = 1'b1;
      @(posedge clk_in) #1;
      @(posedge clk_in) #1;
      rpe_valid_in = 1'b0;
      for (int k = 0; k < 40; k++)
      begin
        v = (k >= g && (k - g) % 3 == 0 && (k - g) / 3 < 13) ? (k - g) / 3 + 1 : 0;
        check("exc", {exc_valid_out, exc_out}, {1'b1, 16'(v)});
        @(posedge clk_in) #1;
      end
      check("exc_end", exc_valid_out, 1'b0);
    end
  endtask : t_rpe

  // Free-running clock
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Reset, then the scenarios in turn
  initial
  begin
    {rst_n_in, op_valid_in, seq_start, frame_par_valid_in, sub_par_valid_in} = '0;
    {rpe_valid_in, res_valid_in, op_req_in, frame_par_in, sub_par_in} = '0;
    {rpe_in, res_in, coef_in} = '0;
    ce_in = 1'b1;
    repeat (12) @(posedge clk_in);
    #1;
    check("rst", {rpe_ready_out, spc_out, op_rsp_out}, {1'b1, 16'h0, 33'h0});
    rst_n_in = 1'b1;
    @(posedge clk_in) #1;
    t_synth;
    t_alu;
    t_frame;
    t_rpe;
    wrap_up;
  end

  // The scenarios need under a thousand cycles; this is far beyond
  initial
  begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule : speech_codec_fixed_point_datapath_test

`default_nettype wire
